// [hw/pswrc_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - each port, upstream and downstream, has a swap bit exchanging its two diff pads.
// - swap 0 puts D+ on the first pad and D- on the second, swap 1 the reverse.
// - swap bits 7 to 1 each control the downstream port of the same number.
// - swap bit 0 set swaps the upstream port pads.
// - the hub reports a downstream port count and also the logical port numbering on LOGICAL_PORT_O.
// - remap fields apply only while the remap enable bit is set.
// - port 2 remap field is bits 7:4 and code 0000 disables port 2.
// - codes 0001 to 0100 map port 2 to logical ports 1 to 4.
// - codes 0101 to 0111 map a port to logical ports 5 to 7.
// - port 1 remap field is bits 3:0, same encoding, 0000 disables it.
// - reserved codes 1000 to 1111 act as 0000, port disabled.
module pswrc_top (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WE_I,
  input wire logic REMAP_MODE_ENABLE_I,
  input wire logic [7:0] CORE_DPLUS_I,
  input wire logic [7:0] CORE_DMINUS_I,
  output logic [7:0] REG_RDATA_O,
  output logic [7:0] PAD_SWAP_BITS_O,
  output logic [7:0] REMAP_FIELD_PORTS_ONE_TWO_O,
  output logic [7:0] FIRST_DIFF_PAD_O,
  output logic [7:0] SECOND_DIFF_PAD_O,
  output logic [7:0] LOGICAL_PORT_O,
  output logic [1:0] PORT_ENABLED_O,
  output logic [2:0] DS_PORT_COUNT_O
);
  pswrc_pkg::pswrc_state_s st_r;
  pswrc_pkg::pswrc_state_s st_nxt;
  pswrc_pkg::pswrc_wr_s wr;
  logic [pswrc_pkg::NUM_REMAP_PORTS*pswrc_pkg::CODE_W-1:0] logical;
  logic [pswrc_pkg::NUM_REMAP_PORTS-1:0] enabled;

  function automatic logic [7:0] reg_read(input logic [7:0] addr,
                                          input logic [7:0] swap,
                                          input logic [7:0] remap);
    if (addr == pswrc_pkg::PAD_SWAP_MASK_OFFS) begin
      reg_read = swap;
    end else if (addr == pswrc_pkg::REMAP_PORTS_ONE_TWO_OFFS) begin
      reg_read = remap;
    end else begin
      reg_read = 8'h00;
    end
  endfunction

  assign wr.addr = REG_ADDR_I;
  assign wr.wdata = REG_WDATA_I;
  assign wr.we = REG_WE_I;

  genvar g;
  generate
    for (g = 0; g < pswrc_pkg::NUM_REMAP_PORTS; g++) begin : g_dec
      pswrc_code_dec u_dec (
        .code_i(st_r.remap_r[g*pswrc_pkg::CODE_W +: pswrc_pkg::CODE_W]),
        .remap_en_i(REMAP_MODE_ENABLE_I),
        .phys_num_i(4'(g + 1)),
        .logical_o(logical[g*pswrc_pkg::CODE_W +: pswrc_pkg::CODE_W]),
        .enabled_o(enabled[g])
      );
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    if (wr.we && wr.addr == pswrc_pkg::PAD_SWAP_MASK_OFFS) begin
      st_nxt.swap_r = wr.wdata;
    end
    if (wr.we && wr.addr == pswrc_pkg::REMAP_PORTS_ONE_TWO_OFFS) begin
      st_nxt.remap_r = wr.wdata;
    end
    st_nxt.rdata_r = reg_read(wr.addr, st_r.swap_r, st_r.remap_r);
    st_nxt.logical_r = logical;
    st_nxt.port_en_r = enabled;
    st_nxt.count_r = 3'({2'b00, enabled[0]} + {2'b00, enabled[1]});
    for (int i = 0; i < pswrc_pkg::NUM_SWAP_PORTS; i++) begin
      // bit 0 is upstream, bits 7:1 downstream port i
      if (st_r.swap_r[i]) begin
        st_nxt.pads_r.first_pad[i] = CORE_DMINUS_I[i];
        st_nxt.pads_r.second_pad[i] = CORE_DPLUS_I[i];
      end else begin
        st_nxt.pads_r.first_pad[i] = CORE_DPLUS_I[i];
        st_nxt.pads_r.second_pad[i] = CORE_DMINUS_I[i];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      st_r <= '0;
      st_r.swap_r <= pswrc_pkg::PAD_SWAP_MASK_RST;
      st_r.remap_r <= pswrc_pkg::REMAP_PORTS_ONE_TWO_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA_O = st_r.rdata_r;
  assign PAD_SWAP_BITS_O = st_r.swap_r;
  assign REMAP_FIELD_PORTS_ONE_TWO_O = st_r.remap_r;
  assign FIRST_DIFF_PAD_O = st_r.pads_r.first_pad;
  assign SECOND_DIFF_PAD_O = st_r.pads_r.second_pad;
  assign LOGICAL_PORT_O = st_r.logical_r;
  assign PORT_ENABLED_O = st_r.port_en_r;
  assign DS_PORT_COUNT_O = st_r.count_r;
endmodule

// [hw/pswrc_pkg.sv]
package pswrc_pkg;
  localparam logic [7:0] PAD_SWAP_MASK_OFFS = 8'hfa;
  localparam logic [7:0] REMAP_PORTS_ONE_TWO_OFFS = 8'hfb;
  localparam logic [7:0] PAD_SWAP_MASK_RST = 8'h00;
  localparam logic [7:0] REMAP_PORTS_ONE_TWO_RST = 8'h00;
  localparam int CODE_W = 4;
  localparam int REMAP_PORT1_LSB = 0;
  localparam int REMAP_PORT2_LSB = 4;
  localparam logic [3:0] CODE_DISABLED = 4'h0;
  localparam logic [3:0] CODE_MAX_LOGICAL = 4'h7;
  localparam int NUM_REMAP_PORTS = 2;
  localparam int NUM_SWAP_PORTS = 8;
  localparam int UPSTREAM_SWAP_BIT = 0;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
  } pswrc_wr_s;

  typedef struct packed {
    logic [NUM_SWAP_PORTS-1:0] first_pad;
    logic [NUM_SWAP_PORTS-1:0] second_pad;
  } pswrc_pads_s;

  typedef struct packed {
    logic [7:0] swap_r;
    logic [7:0] remap_r;
    logic [7:0] rdata_r;
    logic [NUM_REMAP_PORTS*CODE_W-1:0] logical_r;
    logic [NUM_REMAP_PORTS-1:0] port_en_r;
    logic [2:0] count_r;
    pswrc_pads_s pads_r;
  } pswrc_state_s;
endpackage

// [hw/pswrc_code_dec.sv]
`timescale 1ns/1ps
module pswrc_code_dec (
  input wire logic [3:0] code_i,
  input wire logic remap_en_i,
  input wire logic [3:0] phys_num_i,
  output logic [3:0] logical_o,
  output logic enabled_o
);
  always_comb begin
    if (!remap_en_i) begin
      logical_o = phys_num_i;
      enabled_o = 1'b1;
    end else if (code_i == pswrc_pkg::CODE_DISABLED) begin
      logical_o = pswrc_pkg::CODE_DISABLED;
      enabled_o = 1'b0;
    end else if (code_i <= pswrc_pkg::CODE_MAX_LOGICAL) begin
      logical_o = code_i;
      enabled_o = 1'b1;
    end else begin
      logical_o = pswrc_pkg::CODE_DISABLED;
      enabled_o = 1'b0;
    end
  end
endmodule

// [test/pswrc_host_model.sv]
`timescale 1ns/1ps
module pswrc_host_model (
  input wire logic [1:0] en_i,
  output logic [7:0] remap_o
);
  assign remap_o = {en_i[1] ? 4'h1 + 4'(en_i[0]) : 4'h0, 3'h0, en_i[0]};
endmodule

// [test/pswrc_monitor.sv]
`timescale 1ns/1ps
module pswrc_monitor (
  input wire logic CLK_SYS_I, NRST_I, REMAP_MODE_ENABLE_I,
  input wire logic [7:0] CORE_DPLUS_I, CORE_DMINUS_I, PAD_SWAP_BITS_O, FIRST_DIFF_PAD_O,
  input wire logic [7:0] SECOND_DIFF_PAD_O, REMAP_FIELD_PORTS_ONE_TWO_O, LOGICAL_PORT_O,
  input wire logic [1:0] PORT_ENABLED_O,
  input wire logic [2:0] DS_PORT_COUNT_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  wire logic [7:0] sw = PAD_SWAP_BITS_O;
  wire logic [7:0] rm = REMAP_FIELD_PORTS_ONE_TWO_O;
  wire logic [7:0] fp = CORE_DPLUS_I & ~sw | CORE_DMINUS_I & sw;
  wire logic [7:0] sp = CORE_DMINUS_I & ~sw | CORE_DPLUS_I & sw;
  a_up_swap: assert property ($past(NRST_I) |-> FIRST_DIFF_PAD_O[0] == $past(fp[0]))
    else $error("up swap");
  a_down_swap: assert property ($past(NRST_I) |-> FIRST_DIFF_PAD_O[7:1] == $past(fp[7:1]))
    else $error("down swap");
  a_second_pad: assert property ($past(NRST_I) |-> SECOND_DIFF_PAD_O == $past(sp))
    else $error("second pad");
  a_remap_off: assert property ($past(NRST_I) && !$past(REMAP_MODE_ENABLE_I) |->
    LOGICAL_PORT_O == 8'h21) else $error("remap off");
  a_port1_code: assert property ($past(NRST_I) && $past(REMAP_MODE_ENABLE_I) |->
    LOGICAL_PORT_O[3:0] == ($past(rm[3]) ? 4'h0 : $past(rm[3:0]))) else $error("port1");
  a_port2_code: assert property ($past(NRST_I) && $past(REMAP_MODE_ENABLE_I) |->
    LOGICAL_PORT_O[7:4] == ($past(rm[7]) ? 4'h0 : $past(rm[7:4]))) else $error("port2");
  a_port_enable: assert property (PORT_ENABLED_O == {|LOGICAL_PORT_O[7:4], |LOGICAL_PORT_O[3:0]})
    else $error("enable");
  a_port_count: assert property (DS_PORT_COUNT_O == PORT_ENABLED_O[0] + PORT_ENABLED_O[1])
    else $error("count");
endmodule
bind pswrc_top pswrc_monitor u_mon (.*);

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic CLK_SYS_I = 1'b0, NRST_I = 1'b0, REG_WE_I = 1'b0, REMAP_MODE_ENABLE_I = 1'b0;
  logic [7:0] REG_ADDR_I = 8'h00, REG_WDATA_I = 8'h00, CORE_DPLUS_I = 8'h00, CORE_DMINUS_I = 8'h00;
  logic [7:0] REG_RDATA_O, PAD_SWAP_BITS_O, REMAP_FIELD_PORTS_ONE_TWO_O, FIRST_DIFF_PAD_O;
  logic [7:0] SECOND_DIFF_PAD_O, LOGICAL_PORT_O, hm;
  logic [1:0] PORT_ENABLED_O, hen;
  logic [2:0] DS_PORT_COUNT_O;
  logic [3:0] hi, lo;
  logic [7:0] hx [4] = '{8'h00, 8'h01, 8'h10, 8'h21};
  int mismatches = 0, total_checks = 0;
  pswrc_top dut (.*);
  pswrc_host_model u_host (.en_i(hen), .remap_o(hm));
  initial forever #2.5 CLK_SYS_I = ~CLK_SYS_I;
  function automatic logic [3:0] dec(logic [3:0] c);
    return c[3] ? 4'h0 : c;
  endfunction
  task chk(string nm, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge CLK_SYS_I);
    {REG_ADDR_I, REG_WDATA_I, REG_WE_I} <= {a, d, 1'b1};
    @(posedge CLK_SYS_I);
    REG_WE_I <= 1'b0;
    repeat (2) @(posedge CLK_SYS_I);
    #1;
  endtask
  task rd(logic [7:0] a, logic [7:0] e);
    @(posedge CLK_SYS_I);
    REG_ADDR_I <= a;
    @(posedge CLK_SYS_I);
    #1 chk("rdata", REG_RDATA_O, e);
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge CLK_SYS_I);
    NRST_I <= 1'b1;
    rd(8'hfb, 8'h00);
    chk("logical", LOGICAL_PORT_O, 8'h21);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    $display("test reset done");
    @(posedge CLK_SYS_I);
    {CORE_DPLUS_I, CORE_DMINUS_I} <= 16'hf00f;
    wr(8'hfa, 8'ha5);
    chk("first", FIRST_DIFF_PAD_O, 8'h55);
    chk("second", SECOND_DIFF_PAD_O, 8'haa);
    rd(8'hfa, 8'ha5);
    $display("test swap done");
    @(posedge CLK_SYS_I);
    REMAP_MODE_ENABLE_I <= 1'b1;
    for (int e = 1; e < 4; e++) begin
      hen = e[1:0];
      #1 wr(8'hfb, hm);
      chk("host", LOGICAL_PORT_O, hx[e]);
    end
    for (int c = 0; c < 16; c++) begin
      wr(8'hfb, {c[3:0], ~c[3:0]});
      hi = dec(c[3:0]);
      lo = dec(~c[3:0]);
      chk("logical", LOGICAL_PORT_O, {hi, lo});
      chk("count", DS_PORT_COUNT_O, (hi != 0) + (lo != 0));
    end
    @(posedge CLK_SYS_I);
    REMAP_MODE_ENABLE_I <= 1'b0;
    repeat (2) @(posedge CLK_SYS_I);
    #1 chk("off", LOGICAL_PORT_O, 8'h21);
    $display("test remap done");
    report_and_stop();
  end
endmodule
